// *** rtl/lpe_pkg.sv ***
// Constants, field layouts and carrier types for the link parameter engine.
// Assumes the reloadable configuration words arrive as one struct from the
// shared-memory fetch logic, already aligned to the fields below.
package lpe_pkg;

	// ****************************************
	// Custom U-frame control decode
	// ****************************************
	localparam logic [1:0]  UF_TYPE_BITS  = 2'h3;
	localparam logic [7:0]  UF_MATCH_MASK = 8'hec;
	localparam int          UF_CMD_BIT    = 8;
	localparam int          UF_RSP_BIT    = 9;

	// ****************************************
	// Limits and timing
	// ****************************************
	localparam int          IDLE_FIELD_W  = 9;
	localparam int          N200_FIELD_W  = 5;
	localparam logic [8:0]  LIMIT_ZERO_AS = 9'h100;
	localparam logic [16:0] CTS_ZERO_AS   = 17'h10000;
	localparam int          CTS_UNIT_DEF  = 2048;
	localparam int          IDLE_UNIT_DEF = 32'h00a00000;
	localparam int          NUM_Q         = 6;

	// ****************************************
	// Event enable mask bit positions
	// ****************************************
	localparam int MB_MGMT    = 29;
	localparam int MB_L2OVF   = 14;
	localparam int MB_LKOVF   = 13;
	localparam int MB_CTS_TMO = 10;
	localparam int MB_IRETX   = 9;
	localparam int MB_LINKERR = 8;

	// Queue entry codes; the two unmaskable ones sit on always-zero mask bits
	localparam logic [4:0] EVC_BUS_ERR = 5'h1f;
	localparam logic [4:0] EVC_IQ_OVF  = 5'h1c;

	// Pending event sources, lower index served first
	localparam int SRC_BUS = 0;
	localparam int SRC_IQOVF = 1;
	localparam int SRC_MGMT = 2;
	localparam int SRC_CTS = 3;
	localparam int SRC_IRETX = 4;
	localparam int SRC_L2 = 5;
	localparam int SRC_LK = 6;
	localparam int NSRC = 7;

	// Supervisory counter kinds
	localparam logic [1:0] KIND_REJ_TX = 2'h0;
	localparam logic [1:0] KIND_RNR_TX = 2'h1;
	localparam logic [1:0] KIND_REJ_RX = 2'h2;
	localparam logic [1:0] KIND_RNR_RX = 2'h3;

	// ****************************************
	// Receive error keep mask bit positions
	// ****************************************
	localparam int PM_N201 = 3;
	localparam int PM_OVR  = 2;
	localparam int PM_ABT  = 1;
	localparam int PM_CRC  = 0;

	typedef struct packed {
		logic [15:0] custom_uframe_match;
		logic [15:0] idle_link_timeout;
		logic [7:0]  info_frame_retry_limit;
		logic [7:0]  command_retry_limit;
		logic [7:0]  reject_sent_limit;
		logic [7:0]  not_ready_sent_limit;
		logic [7:0]  reject_recv_limit;
		logic [7:0]  not_ready_recv_limit;
		logic [15:0] send_grant_wait_limit;
		logic [15:0] info_queue0_burst;
		logic [15:0] info_queue1_burst;
		logic [15:0] info_queue2_burst;
		logic [15:0] info_queue3_burst;
		logic [15:0] ident_queue0_burst;
		logic [15:0] ident_queue1_burst;
		logic [31:0] event_enable_mask;
		logic [15:0] link_rx_error_keep_mask;
	} lpe_cfg_t;

	typedef struct packed {
		logic [4:0] code;
		logic [7:0] link;
		logic [1:0] kind;
	} lpe_iq_entry_t;

	// Bit order matches the keep mask layout
	typedef struct packed {
		logic n201;
		logic overrun;
		logic abort;
		logic crc;
	} lpe_rx_err_t;

endpackage

// *** rtl/lpe_link_param_engine.sv ***
// Reloadable link parameters and the timers, counters, scheduler and masks
// they steer. Assumes the frame engine reports events as one-cycle pulses on
// sys_clk and that transmit_line_clock is free of sys_clk in phase.
//
// Behaviour
// - Custom U control: type, match bits, C/R
// - Idle limit low nine bits, 2^20x10 units
// - I-frame retry limit raises event, zero=256
// - N200 low five bits, then management error
// - Per-link REJ/RNR sent/received threshold counters
// - Reinit only that counter after queue write
// - REJ/RNR threshold zero means 256
// - CTS wait limit times 2048 line clocks
// - Reload and repeat CTS event until granted
// - CTS wait limit zero means 10000 hex
// - Rotate I0-I3, ident0, ident1 within bursts
// - Zero burst queue never served
// - Enabled events queued, pin unless polling
// - Bus error, queue overflow never masked
// - Unkept error frame is overwritten, discarded
// - Error mask checked overrun, abort, CRC, N201
// - Kept error frame skips counter decrement
// - Keep mask layout, valid only protocol links
// - Fixed event mask bit layout
`timescale 1ns/1ps
module lpe_link_param_engine #(
	parameter int NUM_LINKS       = 4,
	parameter int CTS_UNIT_CYCLES = lpe_pkg::CTS_UNIT_DEF,
	parameter int IDLE_UNIT       = lpe_pkg::IDLE_UNIT_DEF,
	parameter int LINK_W          = $clog2(NUM_LINKS)
) (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic                  transmit_line_clock,
	input  wire lpe_pkg::lpe_cfg_t     cfg,
	input  wire logic                  cfg_reload,
	input  wire logic                  poll_mode,
	input  wire logic                  uframe_valid,
	input  wire logic [7:0]            uframe_ctrl,
	input  wire logic                  uframe_is_cmd,
	input  wire logic                  uframe_is_std,
	output logic                       uframe_accept,
	input  wire logic                  link_established,
	input  wire logic                  link_activity,
	output logic                       idle_expired,
	input  wire logic                  iframe_retx,
	input  wire logic [8:0]            iframe_retx_num,
	input  wire logic                  cmd_retx,
	input  wire logic [5:0]            cmd_retx_num,
	output logic                       cmd_retx_permit,
	input  wire logic                  sup_valid,
	input  wire logic [LINK_W-1:0]     sup_link,
	input  wire logic [1:0]            sup_kind,
	input  wire logic                  ext_bus_error,
	input  wire logic                  ext_iq_overflow,
	input  wire logic                  ext_l2_overflow,
	input  wire logic                  ext_lookup_overflow,
	output logic                       iq_valid,
	input  wire logic                  iq_ready,
	output lpe_pkg::lpe_iq_entry_t     iq_entry,
	output logic                       interrupt_request_pin,
	input  wire logic                  irq_ack,
	input  wire logic                  rts_active,
	input  wire logic                  cts_pin,
	input  wire logic [5:0]            q_has_frame,
	input  wire logic                  q_sent,
	output logic                       sched_valid,
	output logic [2:0]                 sched_queue,
	input  wire logic                  rx_valid,
	input  wire lpe_pkg::lpe_rx_err_t  rx_err,
	input  wire logic                  rx_mask_valid,
	input  wire logic                  rx_protocol,
	output logic                       rx_done,
	output logic                       rx_keep,
	output logic [3:0]                 rx_cause,
	output logic [3:0]                 rx_dec
);

	// ****************************************
	// State types
	// ****************************************
	typedef struct packed {
		lpe_pkg::lpe_cfg_t                cfg;
		logic                             uf_acc;
		logic [31:0]                      idle_pre;
		logic [8:0]                       idle_units;
		logic                             idle_exp;
		logic                             permit;
		logic [lpe_pkg::NSRC-1:0]         pend;
		logic [NUM_LINKS-1:0][3:0][8:0]   cnt;
		logic [NUM_LINKS-1:0][3:0]        lpend;
		logic                             iq_v;
		lpe_pkg::lpe_iq_entry_t           iq_e;
		logic                             irq;
		logic [2:0]                       cur;
		logic [15:0]                      sent;
		logic                             rx_done;
		logic                             rx_keep;
		logic [3:0]                       rx_cause;
		logic [3:0]                       rx_dec;
		logic                             cfg_tog;
		logic                             ev_s1;
		logic                             ev_s2;
		logic                             ev_s3;
	} lpe_sys_state_t;

	typedef struct packed {
		logic        rst_s1;
		logic        rst_s2;
		logic        rts_s1;
		logic        rts_s2;
		logic        cts_s1;
		logic        cts_s2;
		logic        tog_s1;
		logic        tog_s2;
		logic        tog_s3;
		logic [16:0] thr;
		logic [31:0] cnt;
		logic        ev_tog;
	} lpe_tx_state_t;

	lpe_sys_state_t s_q;
	lpe_sys_state_t s_d;
	lpe_tx_state_t  t_q;
	lpe_tx_state_t  t_d;

	// Zero in an 8-bit limit stands for 256
	function automatic logic [8:0] lpe_eff(input logic [7:0] v);
		lpe_eff = (v == 8'h00) ? lpe_pkg::LIMIT_ZERO_AS : {1'b0, v};
	endfunction

	function automatic logic [8:0] lpe_kind_lim(input lpe_pkg::lpe_cfg_t c, input logic [1:0] k);
		case (k)
			lpe_pkg::KIND_REJ_TX: lpe_kind_lim = lpe_eff(c.reject_sent_limit);
			lpe_pkg::KIND_RNR_TX: lpe_kind_lim = lpe_eff(c.not_ready_sent_limit);
			lpe_pkg::KIND_REJ_RX: lpe_kind_lim = lpe_eff(c.reject_recv_limit);
			default:              lpe_kind_lim = lpe_eff(c.not_ready_recv_limit);
		endcase
	endfunction

	// ****************************************
	// Combinational helpers
	// ****************************************
	logic [5:0][15:0]         burst;
	logic [lpe_pkg::NSRC-1:0] ev_in;
	logic [lpe_pkg::NSRC-1:0] ev_en;
	logic [3:0]               eff_keep;
	logic [3:0]               unkept;
	logic [8:0]               n200;
	logic                     cts_evt;

	// Burst table in service order
	assign burst = {s_q.cfg.ident_queue1_burst, s_q.cfg.ident_queue0_burst, s_q.cfg.info_queue3_burst,
	                s_q.cfg.info_queue2_burst, s_q.cfg.info_queue1_burst, s_q.cfg.info_queue0_burst};
	assign n200 = {4'h0, s_q.cfg.command_retry_limit[lpe_pkg::N200_FIELD_W-1:0]};
	assign cts_evt = s_q.ev_s2 ^ s_q.ev_s3;
	// keep mask only on protocol links
	assign eff_keep = (rx_mask_valid && rx_protocol) ? s_q.cfg.link_rx_error_keep_mask[3:0] : 4'h0;
	assign unkept = rx_err & ~eff_keep;

	// enable per source; unmaskable ones fixed on
	assign ev_en = {s_q.cfg.event_enable_mask[lpe_pkg::MB_LKOVF], s_q.cfg.event_enable_mask[lpe_pkg::MB_L2OVF],
	                s_q.cfg.event_enable_mask[lpe_pkg::MB_IRETX], s_q.cfg.event_enable_mask[lpe_pkg::MB_CTS_TMO],
	                s_q.cfg.event_enable_mask[lpe_pkg::MB_MGMT], 1'b1, 1'b1};
	assign ev_in = {ext_lookup_overflow, ext_l2_overflow,
	                iframe_retx && (iframe_retx_num == lpe_eff(s_q.cfg.info_frame_retry_limit)),
	                cts_evt, cmd_retx && ({3'h0, cmd_retx_num} == n200), ext_iq_overflow, ext_bus_error};

	// ****************************************
	// System-domain next state
	// ****************************************
	always_comb
	begin
		int                     l;
		int                     k;
		logic                   found;
		logic [8:0]             nc;
		lpe_pkg::lpe_iq_entry_t ent;
		l = 0;
		k = 0;
		found = 1'b0;
		nc = 9'h000;
		ent = '0;
		s_d = s_q;
		// Event toggle from the line domain, edge taken on the later stages
		s_d.ev_s1 = t_q.ev_tog;
		s_d.ev_s2 = s_q.ev_s1;
		s_d.ev_s3 = s_q.ev_s2;
		// copy the reloadable area on command
		if (cfg_reload)
		begin
			s_d.cfg = cfg;
			s_d.cfg_tog = ~s_q.cfg_tog;
		end
		s_d.uf_acc = uframe_valid && !uframe_is_std && (uframe_ctrl[1:0] == lpe_pkg::UF_TYPE_BITS)
		             && (((uframe_ctrl ^ s_q.cfg.custom_uframe_match[7:0]) & lpe_pkg::UF_MATCH_MASK) == 8'h00)
		             && (uframe_is_cmd ? s_q.cfg.custom_uframe_match[lpe_pkg::UF_CMD_BIT]
		                               : s_q.cfg.custom_uframe_match[lpe_pkg::UF_RSP_BIT]);
		// any frame or a fresh setting restarts the idle timer
		s_d.idle_exp = 1'b0;
		if (!link_established || link_activity || cfg_reload
		    || s_q.cfg.idle_link_timeout[lpe_pkg::IDLE_FIELD_W-1:0] == 9'h000)
		begin
			s_d.idle_pre = 32'h0;
			s_d.idle_units = 9'h000;
		end
		// unit prescaler, then unit count against the low nine bits
		else if (s_q.idle_pre == 32'(IDLE_UNIT - 1))
		begin
			s_d.idle_pre = 32'h0;
			s_d.idle_units = s_q.idle_units + 9'h001;
			if (s_d.idle_units == s_q.cfg.idle_link_timeout[lpe_pkg::IDLE_FIELD_W-1:0])
			begin
				s_d.idle_exp = 1'b1;
				s_d.idle_units = 9'h000;
			end
		end
		else
			s_d.idle_pre = s_q.idle_pre + 32'h1;
		// command frames may go again while below N200
		s_d.permit = ({3'h0, cmd_retx_num} < n200);
		// pin is held until acknowledged; a new write wins over the ack
		if (irq_ack)
			s_d.irq = 1'b0;
		if (s_q.iq_v && iq_ready)
		begin
			s_d.iq_v = 1'b0;
			if (!poll_mode)
				s_d.irq = 1'b1;
			// reinit only the counter behind this entry
			if (s_q.iq_e.code == 5'(lpe_pkg::MB_LINKERR))
			begin
				s_d.cnt[s_q.iq_e.link[LINK_W-1:0]][s_q.iq_e.kind] = 9'h000;
				s_d.lpend[s_q.iq_e.link[LINK_W-1:0]][s_q.iq_e.kind] = 1'b0;
			end
		end
		if (sup_valid && !s_d.lpend[sup_link][sup_kind])
		begin
			nc = s_d.cnt[sup_link][sup_kind] + 9'h001;
			s_d.cnt[sup_link][sup_kind] = nc;
			if (nc == lpe_kind_lim(s_q.cfg, sup_kind))
			begin
				if (s_q.cfg.event_enable_mask[lpe_pkg::MB_LINKERR])
					s_d.lpend[sup_link][sup_kind] = 1'b1;
				else
					s_d.cnt[sup_link][sup_kind] = 9'h000;
			end
		end
		// enabled events go pending; set wins over the load
		if (!s_d.iq_v)
		begin
			for (int i = lpe_pkg::NSRC - 1; i >= 0; i--)
			begin
				if (s_q.pend[i])
				begin
					found = 1'b1;
					l = i;
				end
			end
			if (found)
			begin
				case (l)
					lpe_pkg::SRC_BUS:   ent.code = lpe_pkg::EVC_BUS_ERR;
					lpe_pkg::SRC_IQOVF: ent.code = lpe_pkg::EVC_IQ_OVF;
					lpe_pkg::SRC_MGMT:  ent.code = 5'(lpe_pkg::MB_MGMT);
					lpe_pkg::SRC_CTS:   ent.code = 5'(lpe_pkg::MB_CTS_TMO);
					lpe_pkg::SRC_IRETX: ent.code = 5'(lpe_pkg::MB_IRETX);
					lpe_pkg::SRC_L2:    ent.code = 5'(lpe_pkg::MB_L2OVF);
					default:            ent.code = 5'(lpe_pkg::MB_LKOVF);
				endcase
				s_d.pend[l] = 1'b0;
				s_d.iq_v = 1'b1;
				s_d.iq_e = ent;
			end
			else
			begin
				// Link thresholds only when no global event waits
				for (int i = NUM_LINKS - 1; i >= 0; i--)
				begin
					for (int j = 3; j >= 0; j--)
					begin
						if (s_q.lpend[i][j] && !found)
						begin
							found = 1'b1;
							l = i;
							k = j;
						end
					end
				end
				if (found)
				begin
					s_d.iq_v = 1'b1;
					s_d.iq_e.code = 5'(lpe_pkg::MB_LINKERR);
					s_d.iq_e.link = 8'(l);
					s_d.iq_e.kind = 2'(k);
				end
			end
		end
		s_d.pend = s_d.pend | (ev_in & ev_en);
		// skip empty or zero-burst queues, rotate on burst end
		if (burst[s_q.cur] == 16'h0000 || !q_has_frame[s_q.cur]
		    || (q_sent && (s_q.sent + 16'h0001 >= burst[s_q.cur])))
		begin
			s_d.cur = (s_q.cur == 3'(lpe_pkg::NUM_Q - 1)) ? 3'h0 : s_q.cur + 3'h1;
			s_d.sent = 16'h0000;
		end
		else if (q_sent)
			s_d.sent = s_q.sent + 16'h0001;
		// keep decision and first failing check
		s_d.rx_done = rx_valid;
		s_d.rx_keep = (unkept == 4'h0);
		s_d.rx_dec = rx_valid ? unkept : 4'h0;
		s_d.rx_cause = 4'h0;
		if (unkept[lpe_pkg::PM_OVR])
			s_d.rx_cause[lpe_pkg::PM_OVR] = 1'b1;
		else if (unkept[lpe_pkg::PM_ABT])
			s_d.rx_cause[lpe_pkg::PM_ABT] = 1'b1;
		else if (unkept[lpe_pkg::PM_CRC])
			s_d.rx_cause[lpe_pkg::PM_CRC] = 1'b1;
		else if (unkept[lpe_pkg::PM_N201])
			s_d.rx_cause[lpe_pkg::PM_N201] = 1'b1;
		if (!nrst)
			s_d = '0;
	end

	// System-domain register
	always_ff @(posedge sys_clk)
	begin
		s_q <= s_d;
	end

	// ****************************************
	// Line-clock domain: clear-to-send wait
	// ****************************************
	always_comb
	begin
		logic [16:0] eff;
		logic [31:0] total;
		eff = 17'h00000;
		total = 32'h0;
		t_d = t_q;
		// Two-stage synchronisers, first stage read by nothing else
		t_d.rst_s1 = nrst;
		t_d.rst_s2 = t_q.rst_s1;
		t_d.rts_s1 = rts_active;
		t_d.rts_s2 = t_q.rts_s1;
		t_d.cts_s1 = cts_pin;
		t_d.cts_s2 = t_q.cts_s1;
		t_d.tog_s1 = s_q.cfg_tog;
		t_d.tog_s2 = t_q.tog_s1;
		t_d.tog_s3 = t_q.tog_s2;
		// Limit word is steady well before its toggle arrives here
		if (t_q.tog_s2 ^ t_q.tog_s3)
			t_d.thr = {1'b0, s_q.cfg.send_grant_wait_limit};
		// zero limit waits the longest period
		eff = (t_q.thr == 17'h00000) ? lpe_pkg::CTS_ZERO_AS : t_q.thr;
		// period is limit times the unit in line clocks
		total = 32'(eff) * 32'(CTS_UNIT_CYCLES);
		// grant or withdrawal stops and clears the wait
		if (!t_q.rts_s2 || t_q.cts_s2)
			t_d.cnt = 32'h0;
		else if (t_q.cnt == 32'h0)
			t_d.cnt = total;
		// expiry raises the event and starts over
		else if (t_q.cnt == 32'h1)
		begin
			t_d.cnt = total;
			t_d.ev_tog = ~t_q.ev_tog;
		end
		else
			t_d.cnt = t_q.cnt - 32'h1;
		if (!t_q.rst_s2)
		begin
			t_d.thr = 17'h00000;
			t_d.cnt = 32'h0;
			t_d.ev_tog = 1'b0;
		end
	end

	// Line-domain register
	always_ff @(posedge transmit_line_clock)
	begin
		t_q <= t_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign uframe_accept = s_q.uf_acc;
	assign idle_expired = s_q.idle_exp;
	assign cmd_retx_permit = s_q.permit;
	assign iq_valid = s_q.iq_v;
	assign iq_entry = s_q.iq_e;
	assign interrupt_request_pin = s_q.irq;
	// Handshake output, combinational from registered state and q_has_frame
	assign sched_valid = (burst[s_q.cur] != 16'h0000) && q_has_frame[s_q.cur];
	assign sched_queue = s_q.cur;
	assign rx_done = s_q.rx_done;
	assign rx_keep = s_q.rx_keep;
	assign rx_cause = s_q.rx_cause;
	assign rx_dec = s_q.rx_dec;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_iq_write;
		s_q.iq_v && iq_ready;
	endsequence

	property p_uf_type;
		@(posedge sys_clk) disable iff (!nrst)
		uframe_valid && uframe_ctrl[1:0] != lpe_pkg::UF_TYPE_BITS |=> !uframe_accept;
	endproperty
	a_uf_type: assert property (p_uf_type) else $error("non-U control accepted");

	property p_idle_quiet;
		@(posedge sys_clk) disable iff (!nrst)
		link_activity |=> !idle_expired ##1 !idle_expired;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle expiry right after activity");

	property p_iretx;
		@(posedge sys_clk) disable iff (!nrst)
		iframe_retx && iframe_retx_num == lpe_eff(s_q.cfg.info_frame_retry_limit)
		&& s_q.cfg.event_enable_mask[lpe_pkg::MB_IRETX] |=> s_q.pend[lpe_pkg::SRC_IRETX] || s_q.iq_v;
	endproperty
	a_iretx: assert property (p_iretx) else $error("retry limit event lost");

	property p_mgmt_masked;
		@(posedge sys_clk) disable iff (!nrst)
		!s_q.cfg.event_enable_mask[lpe_pkg::MB_MGMT] && !s_q.pend[lpe_pkg::SRC_MGMT] && !cfg_reload
		|=> !s_q.pend[lpe_pkg::SRC_MGMT];
	endproperty
	a_mgmt_masked: assert property (p_mgmt_masked) else $error("masked management event queued");

	property p_bus_err;
		@(posedge sys_clk) disable iff (!nrst)
		ext_bus_error |=> s_q.pend[lpe_pkg::SRC_BUS] || (s_q.iq_v && s_q.iq_e.code == lpe_pkg::EVC_BUS_ERR);
	endproperty
	a_bus_err: assert property (p_bus_err) else $error("bus error not reported");

	property p_cnt_reinit;
		@(posedge sys_clk) disable iff (!nrst)
		s_iq_write and s_q.iq_e.code == 5'(lpe_pkg::MB_LINKERR) && !sup_valid
		|-> s_d.cnt[s_q.iq_e.link[LINK_W-1:0]][s_q.iq_e.kind] == 9'h000;
	endproperty
	a_cnt_reinit: assert property (p_cnt_reinit) else $error("threshold counter kept");

	property p_irq_set;
		@(posedge sys_clk) disable iff (!nrst)
		s_iq_write and !poll_mode |=> interrupt_request_pin;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("request pin not raised");

	property p_zero_burst;
		@(posedge sys_clk) disable iff (!nrst)
		sched_valid |-> burst[sched_queue] != 16'h0000;
	endproperty
	a_zero_burst: assert property (p_zero_burst) else $error("zero burst queue served");

	property p_rotate;
		@(posedge sys_clk) disable iff (!nrst)
		sched_valid && q_sent && s_q.sent + 16'h0001 >= burst[s_q.cur] |=> sched_queue != $past(sched_queue);
	endproperty
	a_rotate: assert property (p_rotate) else $error("burst limit overrun");

	property p_keep;
		@(posedge sys_clk) disable iff (!nrst)
		rx_valid && rx_err != 4'h0 && unkept == 4'h0 |=> rx_keep && rx_dec == 4'h0;
	endproperty
	a_keep: assert property (p_keep) else $error("kept frame decremented");

	property p_order;
		@(posedge sys_clk) disable iff (!nrst)
		rx_valid && unkept[lpe_pkg::PM_OVR] |=> rx_cause == 4'h4 && !rx_keep;
	endproperty
	a_order: assert property (p_order) else $error("overrun not checked first");

	property p_cts_clear;
		@(posedge transmit_line_clock) disable iff (!t_q.rst_s2)
		t_q.cts_s2 |=> t_q.cnt == 32'h0;
	endproperty
	a_cts_clear: assert property (p_cts_clear) else $error("wait kept after grant");

	property p_cts_reload;
		@(posedge transmit_line_clock) disable iff (!t_q.rst_s2)
		t_q.rts_s2 && !t_q.cts_s2 && t_q.cnt == 32'h1 |=> t_q.ev_tog != $past(t_q.ev_tog) && t_q.cnt > 32'h1;
	endproperty
	a_cts_reload: assert property (p_cts_reload) else $error("wait expiry not repeated");

endmodule // lpe_link_param_engine

// *** sim/lpe_host_model.sv ***
// Host side model: holds the reloadable area and issues reload.
// Assumes the bench hands over a full area image and a one-cycle request.
`timescale 1ns/1ps
module lpe_host_model (
	input  wire logic              sys_clk,
	input  wire logic              load_req,
	input  wire lpe_pkg::lpe_cfg_t image,
	output lpe_pkg::lpe_cfg_t      cfg,
	output logic                   cfg_reload
);
	initial cfg_reload = 1'b0;
	always @(posedge sys_clk)
	begin
		cfg_reload <= load_req;
		if (load_req)
			cfg <= image;
	end
endmodule // lpe_host_model

// *** sim/lpe_link_param_engine_tb.sv ***
// Self-checking bench for the link parameter engine.
// Assumes short timer units so the clear-to-send wait ends quickly.
`timescale 1ns/1ps
module lpe_link_param_engine_tb;
	logic sys_clk = 0, nrst = 0, lclk = 0, load_req = 0, rel = 0, poll = 0;
	logic uv = 0, ucmd = 0, ustd = 0, est = 0, act = 0, irt = 0, crt = 0, sv = 0;
	logic e_bus = 0, e_iq = 0, e_l2 = 0, e_lk = 0, iqr = 1, ack = 0, rts = 0, cts = 0;
	logic qs = 0, rv = 0, mv = 1, prot = 0, uacc, iqv, pin, rdone, rkeep;
	logic [7:0] uctl = 0;
	logic [1:0] slink = 0, skind = 0;
	logic [5:0] qhf = 0;
	logic schv;
	logic [3:0] rcause, rdec;
	lpe_pkg::lpe_rx_err_t rerr = '0;
	lpe_pkg::lpe_cfg_t img = '0, cfg;
	lpe_pkg::lpe_iq_entry_t ent, got;
	int errors = 0, checks_done = 0;
	initial forever #4 sys_clk = ~sys_clk;
	initial forever #6 lclk = ~lclk;
	lpe_host_model host (.sys_clk(sys_clk), .load_req(load_req), .image(img), .cfg(cfg), .cfg_reload(rel));
	lpe_link_param_engine #(.CTS_UNIT_CYCLES(4), .IDLE_UNIT(8)) dut (.sys_clk(sys_clk), .nrst(nrst),
		.transmit_line_clock(lclk), .cfg(cfg), .cfg_reload(rel), .poll_mode(poll), .uframe_valid(uv),
		.uframe_ctrl(uctl), .uframe_is_cmd(ucmd), .uframe_is_std(ustd), .uframe_accept(uacc),
		.link_established(est), .link_activity(act), .idle_expired(), .iframe_retx(irt),
		.iframe_retx_num(9'h0), .cmd_retx(crt), .cmd_retx_num(6'h0), .cmd_retx_permit(), .sup_valid(sv),
		.sup_link(slink), .sup_kind(skind), .ext_bus_error(e_bus), .ext_iq_overflow(e_iq),
		.ext_l2_overflow(e_l2), .ext_lookup_overflow(e_lk), .iq_valid(iqv), .iq_ready(iqr),
		.iq_entry(ent), .interrupt_request_pin(pin), .irq_ack(ack), .rts_active(rts), .cts_pin(cts),
		.q_has_frame(qhf), .q_sent(qs), .sched_valid(schv), .sched_queue(), .rx_valid(rv), .rx_err(rerr),
		.rx_mask_valid(mv), .rx_protocol(prot), .rx_done(rdone), .rx_keep(rkeep), .rx_cause(rcause),
		.rx_dec(rdec));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Bounded wait for the next queue entry
	task automatic wait_iq(input logic [4:0] code);
		int n;
		n = 0;
		while (iqv !== 1'b1 && n < 3000)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 3000)
		begin
			errors++;
			end_of_test();
		end
		got = ent;
		chk("iq_code", code, got.code);
		@(posedge sys_clk);
		#1;
	endtask
	task automatic uf(input logic [7:0] c, input logic cm, input logic ex);
		@(posedge sys_clk);
		uv <= 1; uctl <= c; ucmd <= cm;
		@(posedge sys_clk);
		uv <= 0;
		#1 chk("uframe_accept", ex, uacc);
	endtask
	task automatic sup(input logic [1:0] l);
		@(posedge sys_clk);
		sv <= 1; slink <= l;
		@(posedge sys_clk);
		sv <= 0;
	endtask
	task automatic rx(input logic [3:0] er, input logic p, input logic k, input logic [3:0] c);
		@(posedge sys_clk);
		rv <= 1; rerr <= er; prot <= p;
		@(posedge sys_clk);
		rv <= 0;
		#1 chk("rx_keep", k, rkeep);
		chk("rx_cause", c, rcause);
		chk("rx_dec", c, rdec);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		repeat (20) @(posedge sys_clk);
		nrst <= 1;
		img.custom_uframe_match <= 16'h01ac;
		img.reject_sent_limit <= 8'h02;
		img.send_grant_wait_limit <= 16'h0001;
		img.event_enable_mask <= 32'h00000500;
		img.link_rx_error_keep_mask <= 16'h0004;
		@(posedge sys_clk);
		load_req <= 1;
		@(posedge sys_clk);
		load_req <= 0;
		repeat (3) @(posedge sys_clk);
		uf(8'haf, 1, 1);
		uf(8'hbf, 1, 1);
		uf(8'haf, 0, 0);
		uf(8'hef, 1, 0);
		uf(8'hac, 1, 0);
		@(posedge sys_clk);
		e_bus <= 1; e_l2 <= 1;
		@(posedge sys_clk);
		e_bus <= 0; e_l2 <= 0;
		wait_iq(5'h1f);
		chk("irq_pin", 1, pin);
		sup(2'h3);
		sup(2'h2);
		sup(2'h2);
		wait_iq(5'h08);
		chk("link", 2, got.link);
		sup(2'h2);
		sup(2'h3);
		wait_iq(5'h08);
		chk("link", 3, got.link);
		rx(4'b0101, 1, 0, 4'b0001);
		rx(4'b0100, 1, 1, 4'b0000);
		rx(4'b0100, 0, 0, 4'b0100);
		qhf <= 6'h3f;
		@(posedge sys_clk);
		#1 chk("sched_valid", 0, schv);
		@(posedge sys_clk);
		rts <= 1;
		wait_iq(5'h0a);
		wait_iq(5'h0a);
		cts <= 1;
		repeat (10) @(posedge sys_clk);
		end_of_test();
	end
endmodule // lpe_link_param_engine_tb
